// ---- bench/sar_seq_properties.sv ----
// port checker of the converter sequencer, bound to its top module
`timescale 1ns/100ps
module sar_seq_properties (
    input wire logic ref_clk, // system clock
    input wire logic rst, // synchronous reset
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_rdata, // read data
    input wire logic chip_low_power, // standby level
    input wire logic irq_enable, // interrupt enable
    input wire sar_seq_pkg::analog_ctl_s analog_ctl, // analog controls
    input wire logic conversion_busy_bit, // busy status
    input wire logic conversion_done_flag, // completion flag
    input wire logic irq_request // interrupt pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ****************************************************************
    // assertions
    // ****************************************************************
    a_off_no_busy: assert property (!analog_ctl.power_on &&
        !$past(analog_ctl.power_on) |-> !conversion_busy_bit)
        else $error("busy while converter is off");
    a_fall_sets_done: assert property ($fell(conversion_busy_bit) &&
        analog_ctl.power_on |-> conversion_done_flag)
        else $error("finish did not set done");
    a_irq_on_finish: assert property ($fell(conversion_busy_bit) &&
        analog_ctl.power_on && $past(irq_enable) |-> irq_request)
        else $error("missing interrupt request");
    a_irq_cause: assert property (irq_request |->
        $fell(conversion_busy_bit) && conversion_done_flag)
        else $error("spurious interrupt request");
    a_done_sticky: assert property (conversion_done_flag &&
        !(reg_wr && reg_addr == sar_seq_pkg::ADDR_CONTROL)
        |=> conversion_done_flag)
        else $error("done flag cleared by itself");
    a_done_rise: assert property ($rose(conversion_done_flag) |->
        $fell(conversion_busy_bit) || $past(reg_wr))
        else $error("done flag rose without cause");
    a_rdata_idle: assert property (!$past(reg_rd) |->
        reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_convert_hold: assert property (analog_ctl.convert |->
        conversion_busy_bit && !analog_ctl.track)
        else $error("convert without busy or with tracking");
    a_track_power: assert property (analog_ctl.track |->
        analog_ctl.power_on && !chip_low_power)
        else $error("tracking while off or in standby");
    a_tick_busy: assert property (analog_ctl.sar_tick |->
        conversion_busy_bit)
        else $error("conversion clock outside conversion");
    a_busy_bounded: assert property ($rose(conversion_busy_bit) |->
        ##[1:1000] !conversion_busy_bit)
        else $error("conversion never finished");
    c_finish: cover property ($fell(conversion_busy_bit));
    c_irq: cover property (irq_request);
    c_track_first: cover property ($rose(conversion_busy_bit) &&
        analog_ctl.track);
endmodule

bind sar_adc_sequencer_8bit sar_seq_properties u_props (
    .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .chip_low_power(chip_low_power), .irq_enable(irq_enable),
    .analog_ctl(analog_ctl), .conversion_busy_bit(conversion_busy_bit),
    .conversion_done_flag(conversion_done_flag), .irq_request(irq_request)
);

// ---- bench/tb_top.sv ----
// self-checking bench of the converter sequencer
`timescale 1ns/100ps
module tb_top;
    localparam logic [4:0] CONV = 5'h02;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic t3 = 1'b0;
    logic t2 = 1'b0;
    logic comp = 1'b0;
    logic pin = 1'b0;
    logic low_pwr = 1'b0;
    logic irq_en = 1'b0;
    logic ce = 1'b1;
    logic [7:0] core = 8'h00;
    sar_seq_pkg::analog_ctl_s actl;
    logic busy;
    logic done;
    logic irq;
    logic [7:0] exp_q[$];
    int mismatches = 0;
    int n_tests = 0;
    int seed = 45;
    int cycles = 0;
    int i;
    logic [7:0] v;

    initial forever #4 ref_clk = ~ref_clk;

    sar_adc_sequencer_8bit #(.CONV_CLKS(CONV)) u_dut (
        .ref_clk(ref_clk), .rst(rst), .clk_en(ce), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
        .timer3_overflow(t3), .timer2_overflow(t2),
        .companion_busy_write(comp), .external_convert_start(pin),
        .chip_low_power(low_pwr), .irq_enable(irq_en), .core_data(core),
        .analog_ctl(actl), .conversion_busy_bit(busy),
        .conversion_done_flag(done), .irq_request(irq)
    );

    // ****************************************************************
    // checking and bus tasks
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h wanted %h", $time,
                seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    // the expectation is queued; the watcher below compares it
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
    endtask

    always @(posedge ref_clk) rd_d <= rd;
    always @(negedge ref_clk) begin
        if (rd_d) check(rdata, exp_q.pop_front());
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic fire(input logic [2:0] s, input logic [7:0] ctl);
        @(posedge ref_clk);
        if (s == 3'h0) wr_reg(sar_seq_pkg::ADDR_CONTROL, ctl | 8'h10);
        else if (s == 3'h2) pin <= 1'b1;
        else begin
            t3 <= (s == 3'h1);
            t2 <= (s == 3'h3);
            comp <= s[2];
            @(posedge ref_clk);
            t3 <= 1'b0;
            t2 <= 1'b0;
            comp <= 1'b0;
        end
    endtask

    // one conversion: wrong source first, then the chosen one
    task automatic run(input logic [2:0] s, input logic tm,
        input logic [4:0] dv);
        logic [7:0] ctl;
        int n;
        int len;
        ctl = {1'b1, tm, 2'b00, s, 1'b0};
        len = ((tm && s != 3'h2) ? 3 + CONV : CONV) * (dv + 1);
        // the selected input is taken as already set to analog use
        core <= 8'($random(seed));
        irq_en <= s[0];
        wr_reg(sar_seq_pkg::ADDR_CONFIG, {dv, 3'b000});
        // clear the flag first, then start and wait, as software should
        wr_reg(sar_seq_pkg::ADDR_CONTROL, ctl);
        @(negedge ref_clk);
        check(8'(done), 8'h00);
        if (!tm || s == 3'h2) begin
            check(8'(actl.track), 8'h01);
        end
        fire((s == 3'h3) ? 3'h1 : 3'h3, ctl);
        repeat (4) @(negedge ref_clk);
        check(8'(busy), 8'h00);
        fire(s, ctl);
        for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge ref_clk);
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            n++;
            @(posedge ref_clk);
            t3 <= (n == 1);
            @(negedge ref_clk);
        end
        check(8'(n), 8'(len));
        check(8'({done, irq}), 8'({1'b1, s[0]}));
        rd_reg(sar_seq_pkg::ADDR_RESULT, core);
        pin <= 1'b0;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        rd_reg(sar_seq_pkg::ADDR_CONFIG, 8'hF8);
        rd_reg(sar_seq_pkg::ADDR_CONTROL, 8'h00);
        rd_reg(sar_seq_pkg::ADDR_CHANNEL, 8'h00);
        rd_reg(8'h10, 8'h00);
        check(8'(actl.gain), 8'(sar_seq_pkg::GAIN_HALF));
        $display("test reset values done");
        for (i = 0; i < 8; i++) begin
            // divider field stays at 24 or more, a legal sar clock
            v = 8'($random(seed)) | 8'hC0;
            wr_reg(sar_seq_pkg::ADDR_CHANNEL, {v[7:3], i[2:0]});
            rd_reg(sar_seq_pkg::ADDR_CHANNEL, {5'h00, i[2:0]});
            wr_reg(sar_seq_pkg::ADDR_CONFIG, {v[7:3], 1'b1, i[1:0]});
            rd_reg(sar_seq_pkg::ADDR_CONFIG,
                {v[7:3], 1'b0, i[1:0]});
            check(8'({actl.channel, actl.gain}),
                {3'h0, i[2:0], i[1:0]});
        end
        $display("test registers done");
        for (i = 0; i < 8; i++) begin
            // dividers from the smallest legal value up, never faster
            run(i[2:0], i[0] ^ i[1],
                (i == 7) ? 5'h1F : 5'(sar_seq_pkg::DIV_MIN + i));
        end
        $display("test conversions done");
        wr_reg(sar_seq_pkg::ADDR_CONTROL, 8'h00);
        wr_reg(sar_seq_pkg::ADDR_CONTROL, 8'h10);
        repeat (3) @(negedge ref_clk);
        check(8'({actl.power_on, busy}), 8'h00);
        wr_reg(sar_seq_pkg::ADDR_CONFIG, 8'hF8);
        wr_reg(sar_seq_pkg::ADDR_CONTROL, 8'h80);
        low_pwr <= 1'b1;
        @(negedge ref_clk);
        check(8'({actl.power_on, actl.track}), 8'h02);
        @(posedge ref_clk);
        low_pwr <= 1'b0;
        @(negedge ref_clk);
        check(8'({actl.power_on, actl.track}), 8'h03);
        wr_reg(sar_seq_pkg::ADDR_CONTROL, 8'h90);
        repeat (10) @(negedge ref_clk);
        check(8'(busy), 8'h01);
        // a frozen sequencer must not run on: 100 cycles exceed the rest
        @(posedge ref_clk);
        ce <= 1'b0;
        repeat (100) @(posedge ref_clk);
        ce <= 1'b1;
        @(negedge ref_clk);
        check(8'(busy), 8'h01);
        wr_reg(sar_seq_pkg::ADDR_CONTROL, 8'h00);
        repeat (3) @(negedge ref_clk);
        check(8'({busy, done}), 8'h00);
        $display("test shutdown done");
        end_of_test();
    end
endmodule

// ---- design/sar_adc_sequencer_8bit.sv ----
// control, clocking and register logic of the 8-bit converter subsystem
`timescale 1ns/100ps
module sar_adc_sequencer_8bit #(
    parameter logic [4:0] CONV_CLKS = sar_seq_pkg::CONV_SAR_CLKS
) (
    input wire logic ref_clk, // system clock, 125 MHz
    input wire logic rst, // synchronous reset, active high
    input wire logic clk_en, // freezes all state while low
    input wire logic [7:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // register write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic timer3_overflow, // one-cycle pulse
    input wire logic timer2_overflow, // one-cycle pulse
    input wire logic companion_busy_write, // companion busy set pulse
    input wire logic external_convert_start, // asynchronous pin
    input wire logic chip_low_power, // standby or sleep level
    input wire logic irq_enable, // completion interrupt enable
    input wire logic [7:0] core_data, // sar result from analog core
    output sar_seq_pkg::analog_ctl_s analog_ctl, // analog core controls
    output logic conversion_busy_bit, // busy status
    output logic conversion_done_flag, // sticky completion flag
    output logic irq_request // one-cycle interrupt request
);

    // ****************************************************************
    // register state
    // ****************************************************************
    sar_seq_pkg::control_s ctl_r, ctl_nxt;
    sar_seq_pkg::config_s cfg_r, cfg_nxt;
    logic [2:0] channel_r, channel_nxt;
    logic [7:0] result_r, result_nxt;
    logic done_r, done_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic irq_r, irq_nxt;

    // ****************************************************************
    // sequencer state
    // ****************************************************************
    sar_seq_pkg::seq_state_e state_r, state_nxt;
    logic [4:0] div_cnt_r, div_cnt_nxt;
    logic [4:0] tick_cnt_r, tick_cnt_nxt;
    logic ext_s1_r, ext_s2_r, ext_s3_r;

    logic wr_ctl;
    logic busy;
    logic sar_tick;
    logic ext_rise;
    logic trigger;
    logic finish;

    assign wr_ctl = reg_wr && reg_addr == sar_seq_pkg::ADDR_CONTROL;
    assign busy = state_r != sar_seq_pkg::ST_IDLE;
    assign sar_tick = div_cnt_r == cfg_r.divider;
    // the first stage feeds only the second; edges look at stages 2 and 3
    assign ext_rise = ext_s2_r && !ext_s3_r;
    assign finish = state_r == sar_seq_pkg::ST_CONV && sar_tick
        && tick_cnt_r == CONV_CLKS - 5'h01;

    // ****************************************************************
    // start source selection
    // ****************************************************************
    always_comb begin
        if (ctl_r.source[2]) begin
            trigger = companion_busy_write;
        end else begin
            unique case (ctl_r.source)
                sar_seq_pkg::SRC_BUSY_WRITE:
                    trigger = wr_ctl
                        && reg_wdata[sar_seq_pkg::CTL_BUSY_BIT];
                sar_seq_pkg::SRC_TIMER3: trigger = timer3_overflow;
                sar_seq_pkg::SRC_EXT_PIN: trigger = ext_rise;
                sar_seq_pkg::SRC_TIMER2: trigger = timer2_overflow;
                default: trigger = 1'b0;
            endcase
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;
        tick_cnt_nxt = tick_cnt_r;
        div_cnt_nxt = sar_tick ? 5'h00 : div_cnt_r + 5'h01;
        unique case (state_r)
            sar_seq_pkg::ST_IDLE: begin
                // restarting the divider aligns the first tick to the start
                if (trigger) begin
                    div_cnt_nxt = 5'h00;
                    tick_cnt_nxt = 5'h00;
                    if (ctl_r.track_mode
                        && ctl_r.source != sar_seq_pkg::SRC_EXT_PIN) begin
                        state_nxt = sar_seq_pkg::ST_TRACK;
                    end else begin
                        state_nxt = sar_seq_pkg::ST_CONV;
                    end
                end
            end
            sar_seq_pkg::ST_TRACK: begin
                if (sar_tick) begin
                    tick_cnt_nxt = tick_cnt_r + 5'h01;
                    if (tick_cnt_r ==
                        sar_seq_pkg::TRACK_SAR_CLKS - 5'h01) begin
                        tick_cnt_nxt = 5'h00;
                        state_nxt = sar_seq_pkg::ST_CONV;
                    end
                end
            end
            sar_seq_pkg::ST_CONV: begin
                // further triggers are not looked at until idle again
                if (sar_tick) begin
                    tick_cnt_nxt = tick_cnt_r + 5'h01;
                end
                if (finish) begin
                    state_nxt = sar_seq_pkg::ST_IDLE;
                end
            end
            default: state_nxt = sar_seq_pkg::ST_IDLE;
        endcase
        // disabling aborts any conversion and parks the sequencer
        if (!ctl_r.enable) begin
            state_nxt = sar_seq_pkg::ST_IDLE;
            div_cnt_nxt = 5'h00;
            tick_cnt_nxt = 5'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= sar_seq_pkg::ST_IDLE;
            div_cnt_r <= 5'h00;
            tick_cnt_r <= 5'h00;
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else if (clk_en) begin
            state_r <= state_nxt;
            div_cnt_r <= div_cnt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            ext_s1_r <= external_convert_start;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // ****************************************************************
    // registers and read port
    // ****************************************************************
    always_comb begin
        ctl_nxt = ctl_r;
        cfg_nxt = cfg_r;
        channel_nxt = channel_r;
        result_nxt = result_r;
        done_nxt = done_r;
        rdata_nxt = 8'h00;
        irq_nxt = 1'b0;
        if (wr_ctl) begin
            ctl_nxt.enable = reg_wdata[sar_seq_pkg::CTL_ENABLE_BIT];
            ctl_nxt.track_mode = reg_wdata[sar_seq_pkg::CTL_TRACK_BIT];
            ctl_nxt.source = reg_wdata[sar_seq_pkg::CTL_SRC_LSB +: 3];
            done_nxt = reg_wdata[sar_seq_pkg::CTL_DONE_BIT];
        end
        if (reg_wr && reg_addr == sar_seq_pkg::ADDR_CONFIG) begin
            cfg_nxt.divider = reg_wdata[sar_seq_pkg::CFG_DIV_LSB +: 5];
            cfg_nxt.gain = reg_wdata[sar_seq_pkg::CFG_GAIN_LSB +: 2];
        end
        if (reg_wr && reg_addr == sar_seq_pkg::ADDR_CHANNEL) begin
            channel_nxt = reg_wdata[2:0];
        end
        // completion beats a same-cycle software clear
        if (finish) begin
            result_nxt = core_data;
            done_nxt = 1'b1;
            irq_nxt = irq_enable;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                sar_seq_pkg::ADDR_CONTROL:
                    rdata_nxt = {ctl_r.enable, ctl_r.track_mode, done_r,
                        busy, ctl_r.source, 1'b0};
                sar_seq_pkg::ADDR_CONFIG:
                    rdata_nxt = {cfg_r.divider, 1'b0, cfg_r.gain};
                sar_seq_pkg::ADDR_CHANNEL:
                    rdata_nxt = {5'h00, channel_r};
                sar_seq_pkg::ADDR_RESULT: rdata_nxt = result_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctl_r <= sar_seq_pkg::CONTROL_RESET[7:3];
            cfg_r.divider <= sar_seq_pkg::DIV_RESET;
            cfg_r.gain <= sar_seq_pkg::GAIN_RESET;
            channel_r <= sar_seq_pkg::CHANNEL_RESET;
            result_r <= 8'h00;
            done_r <= 1'b0;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else if (clk_en) begin
            ctl_r <= ctl_nxt;
            cfg_r <= cfg_nxt;
            channel_r <= channel_nxt;
            result_r <= result_nxt;
            done_r <= done_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ****************************************************************
    // analog core controls
    // ****************************************************************
    always_comb begin
        analog_ctl.power_on = ctl_r.enable;
        analog_ctl.convert = state_r == sar_seq_pkg::ST_CONV;
        analog_ctl.sar_tick = sar_tick && busy;
        analog_ctl.channel = channel_r;
        analog_ctl.gain = cfg_r.gain;
        if (!ctl_r.enable || chip_low_power) begin
            analog_ctl.track = 1'b0;
        end else if (!ctl_r.track_mode) begin
            analog_ctl.track = !busy;
        end else if (ctl_r.source == sar_seq_pkg::SRC_EXT_PIN) begin
            analog_ctl.track = !busy && !ext_s2_r;
        end else begin
            analog_ctl.track = state_r == sar_seq_pkg::ST_TRACK;
        end
    end

    assign reg_rdata = rdata_r;
    assign conversion_busy_bit = busy;
    assign conversion_done_flag = done_r;
    assign irq_request = irq_r;

endmodule

// ---- design/sar_seq_pkg.sv ----
// constants, register map and carrier types of the 8-bit converter sequencer
// ****************************************************************
// Summary of operation
// - converter, hold and amplifier run only when enabled
// - disabled means shutdown, no conversions at all
// - eight channels chosen by channel select register
// - amplifier gain settable to 0.5, 1, 2 or 4
// - reset leaves gain field at 0.5 setting
// - conversion clock is system clock over divider+1
// - exactly one start source, picked by source field
// - busy bit high for the whole conversion
// - busy falling sets done flag, may request interrupt
// - finished conversion result goes to result register
// - track mode 0 tracks continuously except converting
// - track mode 1 tracks three conversion clocks first
// - low-power external start: track while low, rise converts
// - chip standby or sleep may shut tracking down
// - source codes 000,001,010,011 and 1xx companion
// - gain codes 00=0.5, 01=1, 10=2, 11=4
// ****************************************************************
package sar_seq_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CONTROL = 8'hAA;
    localparam logic [7:0] ADDR_CONFIG = 8'hAB;
    localparam logic [7:0] ADDR_CHANNEL = 8'hAC;
    localparam logic [7:0] ADDR_RESULT = 8'hAD;

    // control register field positions
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_TRACK_BIT = 6;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_SRC_LSB = 1;

    // config register field positions
    localparam int CFG_DIV_LSB = 3;
    localparam int CFG_GAIN_LSB = 0;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [4:0] DIV_RESET = 5'h1F;
    localparam logic [1:0] GAIN_RESET = 2'h0;
    localparam logic [2:0] CHANNEL_RESET = 3'h0;

    // start source encodings
    localparam logic [2:0] SRC_BUSY_WRITE = 3'h0;
    localparam logic [2:0] SRC_TIMER3 = 3'h1;
    localparam logic [2:0] SRC_EXT_PIN = 3'h2;
    localparam logic [2:0] SRC_TIMER2 = 3'h3;

    // gain encodings
    localparam logic [1:0] GAIN_HALF = 2'h0;
    localparam logic [1:0] GAIN_ONE = 2'h1;
    localparam logic [1:0] GAIN_TWO = 2'h2;
    localparam logic [1:0] GAIN_FOUR = 2'h3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam logic [4:0] TRACK_SAR_CLKS = 5'h03;
    localparam logic [4:0] CONV_SAR_CLKS = 5'h08;
    localparam int SYS_CLK_HZ = 125000000;
    localparam int SAR_MAX_HZ = 6000000;
    // smallest legal divider value keeping the conversion clock in range
    localparam int DIV_MIN =
        (SYS_CLK_HZ + SAR_MAX_HZ - 1) / SAR_MAX_HZ - 1;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic enable;
        logic track_mode;
        logic [2:0] source;
    } control_s;

    typedef struct packed {
        logic [4:0] divider;
        logic [1:0] gain;
    } config_s;

    typedef struct packed {
        logic power_on;
        logic track;
        logic convert;
        logic sar_tick;
        logic [2:0] channel;
        logic [1:0] gain;
    } analog_ctl_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TRACK = 2'b01,
        ST_CONV = 2'b10
    } seq_state_e;

endpackage
